// File: dv/plc_cluster_tb.sv
// self-checking bench for the cell cluster
`timescale 1ns/1ps
module plc_cluster_tb;
  // bench drives
  logic clock = 1'h0;
  logic rstn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic clock_enable_0 = 1'h0, clock_enable_1 = 1'h0, sync_clear = 1'h0, sync_load = 1'h0;
  logic [9:0] async_preset_n = 10'h3FF, async_clear_n = 10'h3FF;
  logic [41:0] nxt = 42'h0;
  // design and fabric outputs
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [9:0] table_input_a, table_input_b, table_input_c, table_input_d, comb_out, reg_out;
  logic carry_in, cascade_in, carry_out, cascade_out;
  // bookkeeping
  int n_mismatch = 0, checks_done = 0;
  logic [9:0] q;
  logic [10:0] s;
  logic [20:0] v;
  logic [41:0] w;
  logic [20:0] add_v [5] = '{21'h0FFC01, 21'h155555, 21'h080200, 21'h100000, 21'h0003FF};
  logic [20:0] cnt_v [5] = '{21'h1FFFFF, 21'h1FFFFF, 21'h1003FF, 21'h1FFEF5, 21'h0FFFFF};
  logic [15:0] masks [4] = '{16'hAAAA, 16'hCCCC, 16'hF0F0, 16'hFF00};

  plc_cluster dut (.clock, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .table_input_a, .table_input_b, .table_input_c, .table_input_d, .carry_in,
    .cascade_in, .clock_enable_0, .clock_enable_1, .sync_clear, .sync_load, .async_preset_n,
    .async_clear_n, .comb_out, .reg_out, .carry_out, .cascade_out);
  plc_fabric fab (.clock, .next_word(nxt), .table_input_a, .table_input_b, .table_input_c,
    .table_input_d, .carry_in, .cascade_in);

  // 40 MHz clock
  always #12.5 clock = ~clock;

  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // verdict and end of run
  task stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  // bus write, address and data offered together
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, er);
  endtask : wr

  // bus read with expected data and response
  task rdr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, ed);
    chk(s_axi_rresp, er);
  endtask : rdr

  // same config word into every cell
  task cfg_all(input logic [31:0] c);
    for (int i = 0; i < 10; i++) wr(8'(i * 4), c, plc_pkg::RESP_OKAY);
  endtask : cfg_all

  // new routing word, settled when this returns
  task drv(input logic [41:0] wd);
    @(posedge clock);
    nxt <= wd;
    @(posedge clock);
    #1;
  endtask : drv

  // one edge with the given enables and sync controls
  task pulse(input logic [1:0] ce, input logic clr, input logic ld);
    @(posedge clock);
    {clock_enable_1, clock_enable_0} <= ce;
    sync_clear <= clr;
    sync_load <= ld;
    @(posedge clock);
    {clock_enable_1, clock_enable_0, sync_clear, sync_load} <= 4'h0;
    #1;
  endtask : pulse

  // counter next state, second cell counts up always
  function automatic logic [9:0] cnt(input logic [9:0] cq, ca, cb, input logic ci);
    logic [9:0] n;
    logic en, up;
    for (int i = 0; i < 10; i++) begin
      en = (i == plc_pkg::SECOND_CELL) ? 1'h1 : ca[i];
      up = (i == plc_pkg::SECOND_CELL) ? 1'h1 : cb[i];
      n[i] = cq[i] ^ (en & ci);
      ci = en & ci & (up ? cq[i] : ~cq[i]);
    end
    return n;
  endfunction : cnt

  // watchdog, well beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'h1;
    // reset value, map and refusals
    rdr(8'h00, 32'h0, plc_pkg::RESP_OKAY);
    rdr(8'h30, 32'h0, plc_pkg::RESP_SLVERR);
    wr(plc_pkg::STAT_OFS, 32'h1, plc_pkg::RESP_SLVERR);
    wr(8'h08, 32'hFFFFFFFF, plc_pkg::RESP_OKAY);
    rdr(8'h08, plc_pkg::CFG_WR_MASK, plc_pkg::RESP_OKAY);
    // each table input selected by its mask
    for (int m = 0; m < 4; m++) begin
      cfg_all({16'h0, masks[m]});
      w = {2'h0, {4{10'h12C}}};
      w[10 * m +: 10] = 10'h2D3;
      drv(w);
      chk(comb_out, 10'h2D3);
    end
    wr(8'h00, 32'h0004F0F0, plc_pkg::RESP_OKAY);
    drv({2'h1, 40'h0});
    chk(comb_out[0], 1'h1);
    drv({2'h0, 10'h0, 10'h3FF, 20'h0});
    chk(comb_out[0], 1'h0);
    // cascade as an and-chain in normal mode
    cfg_all(32'h0008AAAA);
    drv({2'h2, 30'h0, 10'h3FF});
    chk(cascade_out, 1'h1);
    drv({2'h2, 30'h0, 10'h3FE});
    chk(cascade_out, 1'h0);
    // packed register takes d, not while carry-in used
    cfg_all(32'h0010AAAA);
    drv({2'h0, 10'h12C, 10'h0, 10'h0, 10'h2D3});
    pulse(2'h0, 1'h0, 1'h0);
    chk(reg_out, 10'h12C);
    wr(8'h00, 32'h0014AAAA, plc_pkg::RESP_OKAY);
    pulse(2'h0, 1'h0, 1'h0);
    chk(reg_out, 10'h12D);
    // first cell feedback toggles after a clear
    // cell 0 on clock enable 0: one toggle per pulse
    wr(8'h00, 32'h00C05555, plc_pkg::RESP_OKAY);
    pulse(2'h1, 1'h1, 1'h0);
    chk(reg_out, 10'h0);
    pulse(2'h1, 1'h0, 1'h0);
    chk(reg_out[0], 1'h1);
    pulse(2'h1, 1'h0, 1'h0);
    chk(reg_out[0], 1'h0);
    // ripple adder with cascade and carry chains together
    cfg_all(32'h0009E896);
    foreach (add_v[k]) begin
      v = add_v[k];
      drv({1'h1, v[20], 20'h0, v[19:10], v[9:0]});
      s = v[9:0] + v[19:10] + v[20];
      chk(comb_out, s[9:0]);
      chk(carry_out, s[10]);
      chk(cascade_out, &s[9:0]);
      pulse(2'h0, 1'h0, 1'h0);
      chk(reg_out, s[9:0]);
    end
    // last sum leaves cascade high and carry low
    rdr(plc_pkg::CHAIN_OFS, 32'h2, plc_pkg::RESP_OKAY);
    // counter on clock enable 0, cleared first
    cfg_all(32'h00430000);
    pulse(2'h1, 1'h1, 1'h0);
    q = 10'h0;
    foreach (cnt_v[k]) begin
      v = cnt_v[k];
      drv({1'h0, v[20], 20'h0, v[19:10], v[9:0]});
      chk(reg_out, q);
      pulse(2'h1, 1'h0, 1'h0);
      q = cnt(q, v[9:0], v[19:10], v[20]);
      chk(reg_out, q);
    end
    drv({2'h0, 10'h0, 10'h2B4, 20'hFFFFF});
    pulse(2'h1, 1'h0, 1'h1);
    chk(reg_out, 10'h2B4);
    rdr(plc_pkg::STAT_OFS, 32'h2B4, plc_pkg::RESP_OKAY);
    // counter moved to clock enable 1
    cfg_all(32'h00630000);
    drv({2'h1, 10'h0, 10'h2B4, 20'hFFFFF});
    pulse(2'h1, 1'h0, 1'h0);
    chk(reg_out, 10'h2B4);
    pulse(2'h2, 1'h0, 1'h0);
    chk(reg_out, 10'h2B5);
    // async clear beats preset, no edge needed
    @(posedge clock);
    async_clear_n <= 10'h3F0;
    async_preset_n <= 10'h0FE;
    #1;
    chk(reg_out, 10'h3B0);
    @(posedge clock);
    async_clear_n <= 10'h3FF;
    async_preset_n <= 10'h3FF;
    stop_test();
  end
endmodule : plc_cluster_tb

// File: dv/plc_fabric.sv
// neighbouring cells and routing feeding the cluster inputs
`timescale 1ns/1ps
module plc_fabric (
  // clock
  input wire logic clock,
  // next routing word {cascade, carry, d, c, b, a}
  input wire logic [41:0] next_word,
  // lines into the cluster
  output logic [9:0] table_input_a,
  output logic [9:0] table_input_b,
  output logic [9:0] table_input_c,
  output logic [9:0] table_input_d,
  output logic carry_in,
  output logic cascade_in
);
  // neighbour registers launch on the clock edge
  logic [41:0] word_q = 42'h0;
  always_ff @(posedge clock) begin
    word_q <= next_word;
  end
  // fan the word out to the routing lines
  assign {cascade_in, carry_in, table_input_d, table_input_c, table_input_b,
    table_input_a} = word_q;
endmodule : plc_fabric

// File: dv/plc_monitor.sv
// bus and register checker for the cell cluster
`timescale 1ns/1ps
module plc_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // cell registers
  input wire logic [9:0] async_preset_n,
  input wire logic [9:0] async_clear_n,
  input wire logic [9:0] reg_out
);
  // read taken this edge
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  // address outside the map
  wire logic unmap = (s_axi_araddr[7:2] > plc_pkg::CFG_LAST_OFS[7:2])
    && (s_axi_araddr[7:2] != plc_pkg::STAT_OFS[7:2])
    && (s_axi_araddr[7:2] != plc_pkg::CHAIN_OFS[7:2]);

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  r_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  b_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  w_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write slot open during response");
  r_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read slot open during response");
  unmap_rd_a: assert property (ar_take && unmap |=> s_axi_rresp == plc_pkg::RESP_SLVERR
    && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
  stat_rd_a: assert property (ar_take && s_axi_araddr == plc_pkg::STAT_OFS
    |=> s_axi_rdata == {22'h0, $past(reg_out)}) else $error("status read wrong");
  aclr_a: assert property ((reg_out & ~async_clear_n) == 10'h0)
    else $error("async clear ignored");
  apre_a: assert property ((~reg_out & ~async_preset_n & async_clear_n) == 10'h0)
    else $error("async preset ignored");

  // main scenarios
  cover property (s_axi_bvalid && s_axi_bready);
  cover property (s_axi_rvalid && s_axi_rresp == plc_pkg::RESP_SLVERR);
  cover property (async_clear_n != 10'h3FF);
endmodule : plc_monitor

bind plc_cluster plc_monitor mon (.clock, .rstn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .async_preset_n, .async_clear_n, .reg_out);

// File: hdl/plc_cell.sv
// one logic_cell: table logic, chain logic and its single register
`timescale 1ns/1ps
module plc_cell #(
  parameter bit IS_SECOND = 1'b0 // the second cell cannot take controls on a/b
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // configuration
  input wire logic [31:0] cfg,
  // local routing data
  input wire logic table_input_a,
  input wire logic table_input_b,
  input wire logic table_input_c,
  input wire logic table_input_d,
  // neighbour chains
  input wire logic carry_in,
  input wire logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // cluster-wide register controls
  input wire logic clock_enable_0,
  input wire logic clock_enable_1,
  input wire logic sync_clear,
  input wire logic sync_load,
  // per-cell asynchronous controls
  input wire logic async_preset_n,
  input wire logic async_clear_n,
  // results
  output logic comb_out,
  output logic reg_out
);

  plc_pkg::plc_mode_t mode; // decoded operating mode
  logic [15:0] mask; // table contents
  logic q_q; // the cell register
  logic fb_en; // feedback allowed and chosen
  logic in_a; // table input a after the feedback mux
  logic in_c; // table input c after the carry mux
  logic lut4; // normal-mode table result
  logic lut_sum; // arithmetic first table
  logic lut_carry; // arithmetic second table
  logic cnt_en; // counter enable
  logic cnt_up; // counter direction
  logic cnt_sum; // counter next bit
  logic cnt_carry; // counter ripple to next cell
  logic reg_d; // register data before clear and load
  logic reg_ce; // selected clock enable

  assign mode = plc_pkg::plc_mode_t'(cfg[plc_pkg::CFG_MODE_LSB +: 2]);
  assign mask = cfg[plc_pkg::CFG_MASK_LSB +: plc_pkg::CFG_MASK_W];

  // feedback of the own register onto input a, not on the second cell
  assign fb_en = cfg[plc_pkg::CFG_FB_EN] && !IS_SECOND;
  assign in_a = fb_en ? q_q : table_input_a;
  // carry-in or data c as the third table input
  assign in_c = cfg[plc_pkg::CFG_USE_CARRY] ? carry_in : table_input_c;

  // four-input table of normal mode
  assign lut4 = mask[{table_input_d, in_c, table_input_b, in_a}];
  // two three-input tables of arithmetic mode: sum in low byte, carry in high byte
  assign lut_sum = mask[{1'b0, carry_in, table_input_b, in_a}];
  assign lut_carry = mask[{1'b1, carry_in, table_input_b, in_a}];

  // counter controls come from local data a and b, fixed on the second cell
  assign cnt_en = IS_SECOND ? 1'b1 : table_input_a;
  assign cnt_up = IS_SECOND ? 1'b1 : table_input_b;
  assign cnt_sum = q_q ^ (cnt_en & carry_in);
  // up ripples on a one, down borrows on a zero
  assign cnt_carry = cnt_en & carry_in & (cnt_up ? q_q : ~q_q);

  // result, carry and register data per mode
  always_comb begin
    case (mode)
      plc_pkg::PLC_MODE_ARITH: begin
        comb_out = lut_sum; // unregistered copy beside the registered one
        carry_out = lut_carry;
        reg_d = lut_sum;
      end
      plc_pkg::PLC_MODE_COUNTER: begin
        comb_out = cnt_sum;
        carry_out = cnt_carry;
        reg_d = cnt_sum;
      end
      default: begin
        comb_out = lut4;
        carry_out = 1'b0; // no carry generated in normal mode
        // packing is refused while carry-in feeds the table
        if (cfg[plc_pkg::CFG_PACK] && !cfg[plc_pkg::CFG_USE_CARRY]) begin
          reg_d = table_input_d;
        end else begin
          reg_d = lut4;
        end
      end
    endcase
  end

  // cascade is an and-chain, usable in normal and arithmetic modes
  assign cascade_out = cfg[plc_pkg::CFG_CASC_EN] ? (comb_out & cascade_in) : comb_out;

  // clock enable picked from the two cluster lines
  assign reg_ce = !cfg[plc_pkg::CFG_CE_USE] ? 1'b1 :
                  (cfg[plc_pkg::CFG_CE_SEL] ? clock_enable_1 : clock_enable_0);

  // the cell register: async clear beats async preset, then sync controls
  always_ff @(posedge clock or negedge async_clear_n or negedge async_preset_n) begin
    if (!async_clear_n) begin
      q_q <= 1'b0;
    end else if (!async_preset_n) begin
      q_q <= 1'b1;
    end else if (!rstn) begin
      q_q <= 1'b0;
    end else if (reg_ce) begin
      if (sync_clear) begin
        q_q <= 1'b0;
      end else if (sync_load) begin
        q_q <= table_input_c;
      end else begin
        q_q <= reg_d;
      end
    end
  end

  assign reg_out = q_q;

endmodule : plc_cell

// File: hdl/plc_cluster.sv
// cell_cluster: ten logic cells, their chains, shared controls and axi4-lite config
//
// Behaviour
// - normal mode: four-input table, carry or input c
// - table result and cascade-in form cascade-out
// - register packing, not while carry-in used
// - arithmetic: sum table and carry table
// - adder sums a, b and carry-in
// - registered and unregistered result both out
// - cascade chain usable together with carry chain
// - counter: enables, direction, sync clear, load
// - counter enable and direction from data inputs
// - sync clear and load act cluster wide
// - two shared clock enables, selected per cell
// - first cell feeds register back to itself
// - a/b carry controls except second cell
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// map: cell words from zero, then status, then chain word
// reads and writes run apart, one of each in flight
module plc_cluster (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,

  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,

  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,

  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,

  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,

  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,

  // local routing data, one bit per cell
  input wire logic [9:0] table_input_a,
  input wire logic [9:0] table_input_b,
  input wire logic [9:0] table_input_c,
  input wire logic [9:0] table_input_d,

  // chains entering the first cell
  input wire logic carry_in,
  input wire logic cascade_in,

  // cluster-wide register controls
  input wire logic clock_enable_0,
  input wire logic clock_enable_1,
  input wire logic sync_clear,
  input wire logic sync_load,

  // per-cell asynchronous controls
  input wire logic [9:0] async_preset_n,
  input wire logic [9:0] async_clear_n,

  // per-cell results
  output logic [9:0] comb_out,
  output logic [9:0] reg_out,

  // chains leaving the last cell
  output logic carry_out,
  output logic cascade_out
);

  // ports stay ten wide; the map has one word per cell
  localparam int N = plc_pkg::NUM_CELLS;

  // configuration store, one word per cell
  // plain flops: every cell reads its own word all the time
  logic [31:0] cfg_q [N];

  // chain wires between neighbours; element i enters cell i
  // both chains ripple through all ten cells within one cycle
  // element N is what leaves the last cell
  logic [N:0] carry_chain;
  logic [N:0] cascade_chain;

  // write channel state
  // whichever half comes first waits in its slot for the other
  logic awready_q; // address slot free
  logic wready_q; // data slot free
  logic aw_held_q; // address taken, waiting for data
  logic w_held_q; // data taken, waiting for address
  logic [7:0] aw_addr_q; // captured write address
  logic [31:0] w_data_q; // captured write data
  logic [3:0] w_strb_q; // captured byte strobes
  logic bvalid_q; // response pending
  logic [1:0] bresp_q; // response code

  // read channel state
  // one read at a time; the slot stays shut until rready
  logic arready_q; // read address slot free
  logic rvalid_q; // read data pending
  logic [31:0] rdata_q; // read data register
  logic [1:0] rresp_q; // read response code

  // decode helpers
  // the indices mean something only for config words
  logic do_write; // both halves held and no response outstanding
  logic wr_hit; // write address maps to a config word
  logic [3:0] wr_idx; // config word index of the write
  logic [31:0] rd_val; // value for the read address
  logic rd_ok; // read address is mapped
  logic [3:0] rd_idx; // config word index of the read

  // chain ends
  // the first cell takes its chains from outside the cluster
  assign carry_chain[0] = carry_in;
  assign cascade_chain[0] = cascade_in;

  // the cells, chained through carry and cascade
  // cell 1 has no feedback and fixed counter controls
  for (genvar i = 0; i < N; i++) begin : g_cell
    plc_cell #(
      .IS_SECOND(i == plc_pkg::SECOND_CELL)
    ) u_cell (
      .clock(clock),
      .rstn(rstn),
      .cfg(cfg_q[i]),
      .table_input_a(table_input_a[i]),
      .table_input_b(table_input_b[i]),
      .table_input_c(table_input_c[i]),
      .table_input_d(table_input_d[i]),
      .carry_in(carry_chain[i]),
      .cascade_in(cascade_chain[i]),
      .carry_out(carry_chain[i+1]),
      .cascade_out(cascade_chain[i+1]),
      .clock_enable_0(clock_enable_0),
      .clock_enable_1(clock_enable_1),
      .sync_clear(sync_clear), // shared by every register
      .sync_load(sync_load), // shared by every register
      .async_preset_n(async_preset_n[i]),
      .async_clear_n(async_clear_n[i]),
      .comb_out(comb_out[i]),
      .reg_out(reg_out[i])
    );
  end

  // chain outputs of the last cell
  // handed on to the next cluster
  assign carry_out = carry_chain[N];
  assign cascade_out = cascade_chain[N];

  // write decode on the captured address
  // low address bits ignored: a register is one aligned word
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_idx = aw_addr_q[5:2];
  assign wr_hit = (aw_addr_q[7:2] <= plc_pkg::CFG_LAST_OFS[7:2]);

  // write address acceptance
  // reopening only after the response keeps one write in flight
  always_ff @(posedge clock) begin
    if (!rstn) begin
      // slot open, nothing held
      awready_q <= 1'b1;
      aw_held_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end else if (s_axi_awvalid && awready_q) begin
      // take the address and close the slot
      awready_q <= 1'b0;
      aw_held_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end else if (do_write) begin
      // slot stays shut until the response is taken
      aw_held_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // response taken: the next write may come
      awready_q <= 1'b1;
    end
  end

  // write data acceptance
  // mirror of the address side, strobes kept with the data
  always_ff @(posedge clock) begin
    if (!rstn) begin
      // slot open, nothing held
      wready_q <= 1'b1;
      w_held_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && wready_q) begin
      // take the data and close the slot
      wready_q <= 1'b0;
      w_held_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end else if (s_axi_bvalid && s_axi_bready) begin
      // response taken: open the data slot again
      wready_q <= 1'b1;
    end
  end

  // write response
  // rises a cycle after both halves are held, stands until bready
  always_ff @(posedge clock) begin
    if (!rstn) begin
      // no response pending
      bvalid_q <= 1'b0;
      bresp_q <= plc_pkg::RESP_OKAY;
    end else if (do_write) begin
      // unmapped addresses answer slave error and store nothing
      bvalid_q <= 1'b1;
      bresp_q <= wr_hit ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      // taken: the slots reopen on this edge too
      bvalid_q <= 1'b0;
    end
  end

  // configuration store, byte lanes by strobe, reserved bits kept zero
  // unmapped writes store nothing
  // a cell sees its new word one cycle after the write
  always_ff @(posedge clock) begin
    if (!rstn) begin
      // every cell wakes in normal mode with an empty table
      for (int k = 0; k < N; k++) begin
        cfg_q[k] <= plc_pkg::CFG_RST;
      end
    end else if (do_write && wr_hit) begin
      // each lane follows its own strobe
      for (int b = 0; b < 4; b++) begin
        if (w_strb_q[b]) begin
          cfg_q[wr_idx][8*b +: 8] <= w_data_q[8*b +: 8] & plc_pkg::CFG_WR_MASK[8*b +: 8];
        end
      end
    end
  end

  // read decode straight from the request address
  // captured into the read data register at the acceptance edge
  // status shows the cell registers as they stood before that edge
  assign rd_idx = s_axi_araddr[5:2];
  always_comb begin
    rd_val = 32'h00000000;
    rd_ok = 1'b1;
    if (s_axi_araddr[7:2] <= plc_pkg::CFG_LAST_OFS[7:2]) begin
      // config word of one cell
      rd_val = cfg_q[rd_idx];
    end else if (s_axi_araddr[7:2] == plc_pkg::STAT_OFS[7:2]) begin
      // live register state of all cells
      rd_val = {22'h000000, reg_out};
    end else if (s_axi_araddr[7:2] == plc_pkg::CHAIN_OFS[7:2]) begin
      // carry in bit 0, cascade in bit 1
      rd_val = {30'h00000000, cascade_out, carry_out};
    end else begin
      // unmapped: zero data, slave error
      rd_ok = 1'b0;
    end
  end

  // read channel
  // unmapped reads are answered too, with an error
  // data stay put until rready, however slow the master
  always_ff @(posedge clock) begin
    if (!rstn) begin
      // ready for a read straight out of reset
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= plc_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && arready_q) begin
      // answer on the next edge and hold until taken
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      // answer taken: reopen the address slot
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  // bus outputs from their registers
  // comb_out and the chain ends stay combinational: the cell must
  // offer an unregistered result and ripple its chains
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : plc_cluster

// File: hdl/plc_pkg.sv
// constants and types shared by the logic cell cluster and its cells
package plc_pkg;

  // cluster geometry
  localparam int NUM_CELLS = 10; // cells per cell_cluster
  localparam int SECOND_CELL = 1; // index of the cell with no a/b control sharing

  // axi4-lite geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] CFG_BASE_OFS = 8'h00; // one config word per cell, 4 bytes apart
  localparam logic [7:0] CFG_LAST_OFS = 8'h24; // config word of the last cell
  localparam logic [7:0] STAT_OFS = 8'h40; // registered outputs of all cells
  localparam logic [7:0] CHAIN_OFS = 8'h44; // carry and cascade leaving the cluster

  // cell config word fields
  localparam int CFG_MASK_LSB = 0; // 16-bit table contents
  localparam int CFG_MASK_W = 16;
  localparam int CFG_MODE_LSB = 16; // 2-bit operating mode
  localparam int CFG_USE_CARRY = 18; // carry-in replaces table_input_c
  localparam int CFG_CASC_EN = 19; // combine table result with cascade-in
  localparam int CFG_PACK = 20; // packed register takes table_input_d
  localparam int CFG_CE_SEL = 21; // 0 picks clock enable 0, 1 picks clock enable 1
  localparam int CFG_CE_USE = 22; // 0 lets the register load on every edge
  localparam int CFG_FB_EN = 23; // register output replaces table_input_a
  localparam logic [31:0] CFG_WR_MASK = 32'h00FFFFFF; // bits 31:24 reserved, read zero
  localparam logic [31:0] CFG_RST = 32'h00000000; // config word after reset

  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // operating modes, gray coded along normal, arithmetic, counter
  typedef enum logic [1:0] {
    PLC_MODE_NORMAL = 2'h0,
    PLC_MODE_ARITH = 2'h1,
    PLC_MODE_COUNTER = 2'h3,
    PLC_MODE_SPARE = 2'h2
  } plc_mode_t;

endpackage : plc_pkg
